// ---- src/ssb_pkg.sv ----
package ssb_pkg;

	// Array geometry
	localparam int SSB_ADDR_W        = 18;
	localparam int SSB_LANES         = 4;
	localparam int SSB_LANE_W        = 9;
	localparam int SSB_DATA_W        = SSB_LANES * SSB_LANE_W;
	localparam int SSB_BEAT_W        = 2;

	// Sleep timing, in clock periods
	localparam int SSB_SLEEP_ENTRY_TCYC    = 2;
	localparam int SSB_SLEEP_RECOVERY_TCYC = 2;
	localparam int SSB_SLEEP_SYNC_STAGES   = SSB_SLEEP_ENTRY_TCYC;

	// Reset value, beat step and default burst order
	localparam logic [SSB_BEAT_W-1:0] SSB_BEAT_RST  = 2'h0;
	localparam logic [SSB_BEAT_W-1:0] SSB_BEAT_ONE  = 2'h1;
	localparam logic                  SSB_ORDER_DEF = 1'h1;

	// Cycle kinds taken at a clock edge
	typedef enum {
		SSB_CYC_IDLE,
		SSB_CYC_DESEL,
		SSB_CYC_RD_EXT,
		SSB_CYC_WR_EXT,
		SSB_CYC_RD_NEXT,
		SSB_CYC_WR_NEXT,
		SSB_CYC_RD_CUR,
		SSB_CYC_WR_CUR
	} ssb_cyc_t;

	// Synchronous control pins
	typedef struct packed {
		logic                 primary_chip_select_n;
		logic                 expansion_select_high;
		logic                 expansion_select_low_n;
		logic                 processor_addr_strobe_n;
		logic                 controller_addr_strobe_n;
		logic                 burst_advance_n;
		logic                 global_write_n;
		logic                 byte_write_gate_n;
		logic [SSB_LANES-1:0] byte_lane_select_n;
	} ssb_ctl_t;

endpackage

// ---- src/ssb_burst_ctr.sv ----
module ssb_burst_ctr (
	// Clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	// Control
	input  wire logic                          load,
	input  wire logic [ssb_pkg::SSB_BEAT_W-1:0] load_val,
	input  wire logic                          step,
	input  wire logic                          interleave,
	// Burst address low bits
	output logic      [ssb_pkg::SSB_BEAT_W-1:0] cur_low,
	output logic      [ssb_pkg::SSB_BEAT_W-1:0] nxt_low
);
	import ssb_pkg::*;

	logic [SSB_BEAT_W-1:0] start_r;
	logic [SSB_BEAT_W-1:0] beat_r;
	logic [SSB_BEAT_W-1:0] beat_nxt;

	assign beat_nxt = SSB_BEAT_W'(beat_r + SSB_BEAT_ONE);

	// Start value and beat index
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			start_r <= SSB_BEAT_RST;
			beat_r  <= SSB_BEAT_RST;
		end else if (load) begin
			start_r <= load_val;
			beat_r  <= SSB_BEAT_RST;
		end else if (step) begin
			beat_r <= beat_nxt;
		end
	end

	// Order select
	always_comb begin
		if (interleave) begin
			cur_low = start_r ^ beat_r;
			nxt_low = start_r ^ beat_nxt;
		end else begin
			cur_low = SSB_BEAT_W'(start_r + beat_r);
			nxt_low = SSB_BEAT_W'(start_r + beat_nxt);
		end
	end

	load_start_a: assert property (@(posedge clk_sys) disable iff (rst)
		load |=> (beat_r == SSB_BEAT_RST) && (start_r == $past(load_val)))
		else $error("burst start not loaded");

	il_order_a: assert property (@(posedge clk_sys) disable iff (rst)
		load ##1 (step && interleave && !load)[*3] |=> cur_low == ($past(load_val, 4) ^ 2'h3))
		else $error("interleaved fourth beat wrong");

	lin_order_a: assert property (@(posedge clk_sys) disable iff (rst)
		(step && !interleave && !load) |=> cur_low == SSB_BEAT_W'($past(cur_low) + SSB_BEAT_ONE))
		else $error("linear beat did not advance by one");

endmodule // ssb_burst_ctr

// ---- src/ssb_sram_ctl.sv ----
module ssb_sram_ctl #(
	parameter int ADDR_W = ssb_pkg::SSB_ADDR_W,
	parameter int LANES  = ssb_pkg::SSB_LANES,
	parameter int LANE_W = ssb_pkg::SSB_LANE_W
) (
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// Synchronous controls and address
	input  wire ssb_pkg::ssb_ctl_t        ctl,
	input  wire logic [ADDR_W-1:0]        addr,
	input  logic                          burst_order_sel = ssb_pkg::SSB_ORDER_DEF,
	// Asynchronous controls
	input  wire logic                     sleep_request,
	input  wire logic                     output_enable_n,
	// Data pins
	input  wire logic [LANES*LANE_W-1:0]  dq_in,
	output logic      [LANES*LANE_W-1:0]  dq_out,
	output logic                          dq_oe
);
	import ssb_pkg::*;

	localparam int DATA_W = LANES * LANE_W;
	localparam int DEPTH  = 2 ** ADDR_W;

	logic [DATA_W-1:0]            mem [DEPTH];
	logic                         sleep_sync_r;
	logic                         asleep_r;
	logic                         burst_r;
	logic                         rd_drive_r;
	logic [DATA_W-1:0]            dq_out_r;
	logic [ADDR_W-1:SSB_BEAT_W]   burst_hi_r;
	logic                         sel;
	logic                         processor_addr_strobe_n_go;
	logic                         wr_ind;
	logic                         is_wr;
	logic                         is_rd;
	ssb_cyc_t                     cyc;
	logic [SSB_BEAT_W-1:0]        cur_low;
	logic [SSB_BEAT_W-1:0]        nxt_low;
	logic [SSB_BEAT_W-1:0]        acc_low;
	logic [ADDR_W-SSB_BEAT_W-1:0] acc_hi;
	logic [ADDR_W-1:0]            acc_addr;
	logic [LANES-1:0]             lane_we;
	logic                         load;
	logic                         step;

	// Sleep request synchroniser, two stages
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sleep_sync_r <= 1'h0;
			asleep_r     <= 1'h0;
		end else begin
			sleep_sync_r <= sleep_request;
			asleep_r     <= sleep_sync_r;
		end
	end

	// Select and write decode
	assign sel     = !ctl.primary_chip_select_n && ctl.expansion_select_high && !ctl.expansion_select_low_n;
	assign processor_addr_strobe_n_go = !ctl.processor_addr_strobe_n && !ctl.primary_chip_select_n;
	assign wr_ind  = !ctl.global_write_n || (!ctl.byte_write_gate_n && !(&ctl.byte_lane_select_n));

	// Cycle decode
	always_comb begin
		cyc = SSB_CYC_IDLE;
		if (asleep_r) begin
			cyc = SSB_CYC_IDLE;
		end else if (processor_addr_strobe_n_go) begin
			cyc = sel ? SSB_CYC_RD_EXT : SSB_CYC_DESEL;
		end else if (!ctl.controller_addr_strobe_n) begin
			if (!sel) begin
				cyc = SSB_CYC_DESEL;
			end else if (wr_ind) begin
				cyc = SSB_CYC_WR_EXT;
			end else begin
				cyc = SSB_CYC_RD_EXT;
			end
		end else if (burst_r) begin
			if (!ctl.burst_advance_n) begin
				cyc = wr_ind ? SSB_CYC_WR_NEXT : SSB_CYC_RD_NEXT;
			end else begin
				cyc = wr_ind ? SSB_CYC_WR_CUR : SSB_CYC_RD_CUR;
			end
		end
	end

	assign is_wr = (cyc == SSB_CYC_WR_EXT) || (cyc == SSB_CYC_WR_NEXT) || (cyc == SSB_CYC_WR_CUR);
	assign is_rd = (cyc == SSB_CYC_RD_EXT) || (cyc == SSB_CYC_RD_NEXT) || (cyc == SSB_CYC_RD_CUR);
	assign load  = (cyc == SSB_CYC_RD_EXT) || (cyc == SSB_CYC_WR_EXT);
	assign step  = (cyc == SSB_CYC_RD_NEXT) || (cyc == SSB_CYC_WR_NEXT);

	ssb_burst_ctr u_ctr (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.load       (load),
		.load_val   (addr[SSB_BEAT_W-1:0]),
		.step       (step),
		.interleave (burst_order_sel),
		.cur_low    (cur_low),
		.nxt_low    (nxt_low)
	);

	// Access address
	always_comb begin
		acc_low = cur_low;
		acc_hi  = burst_hi_r;
		case (cyc)
			SSB_CYC_RD_EXT, SSB_CYC_WR_EXT: begin
				acc_low = addr[SSB_BEAT_W-1:0];
				acc_hi  = addr[ADDR_W-1:SSB_BEAT_W];
			end
			SSB_CYC_RD_NEXT, SSB_CYC_WR_NEXT: begin
				acc_low = nxt_low;
			end
			default: begin
				acc_low = cur_low;
			end
		endcase
	end
	assign acc_addr = {acc_hi, acc_low};

	// Burst state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			burst_r    <= 1'h0;
			burst_hi_r <= '0;
		end else if (asleep_r || cyc == SSB_CYC_DESEL) begin
			burst_r <= 1'h0;
		end else if (load) begin
			burst_r    <= 1'h1;
			burst_hi_r <= addr[ADDR_W-1:SSB_BEAT_W];
		end
	end

	// Per-lane write enables
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		assign lane_we[i] = is_wr && (!ctl.global_write_n ||
			(!ctl.byte_write_gate_n && !ctl.byte_lane_select_n[i]));
	end

	// Array write, no write while asleep
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < LANES; i++) begin
			if (lane_we[i]) begin
				mem[acc_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
			end
		end
	end

	// Read data and drive qualifier
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_drive_r <= 1'h0;
			dq_out_r   <= '0;
		end else begin
			rd_drive_r <= is_rd;
			if (is_rd) begin
				dq_out_r <= mem[acc_addr];
			end
		end
	end

	// Output enable acts without the clock
	assign dq_out = dq_out_r;
	assign dq_oe  = rd_drive_r && !output_enable_n && !sleep_request && !asleep_r;

	sleep_tri_a: assert property (@(posedge clk_sys) disable iff (rst)
		(sleep_request || asleep_r) |-> !dq_oe)
		else $error("data pins driven in sleep");

	sleep_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
		($rose(sleep_request) && !asleep_r) ##1 sleep_request |-> !asleep_r ##1 asleep_r)
		else $error("sleep entry not two clocks");

	sleep_exit_a: assert property (@(posedge clk_sys) disable iff (rst)
		($fell(sleep_request) && asleep_r) ##1 !sleep_request |-> asleep_r ##1 !asleep_r)
		else $error("sleep exit not two clocks");

	sleep_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		asleep_r |-> (lane_we == '0) ##1 !rd_drive_r)
		else $error("access while asleep");

	processor_addr_strobe_n_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(processor_addr_strobe_n_go && sel && !asleep_r) |-> (lane_we == '0) ##1 rd_drive_r)
		else $error("processor strobe start not a read");

	controller_addr_strobe_n_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!asleep_r && !processor_addr_strobe_n_go && !ctl.controller_addr_strobe_n && sel && !ctl.global_write_n)
		|-> (&lane_we) ##1 !dq_oe)
		else $error("controller strobe write missed");

	write_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
		is_wr |=> !dq_oe)
		else $error("pins driven after write");

	desel_tri_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cyc == SSB_CYC_DESEL) |=> !dq_oe && !burst_r)
		else $error("deselect left pins driven");

	lin_next_a: assert property (@(posedge clk_sys) disable iff (rst)
		(step && !burst_order_sel) |=> cur_low == SSB_BEAT_W'($past(cur_low) + SSB_BEAT_ONE))
		else $error("linear order not used");

	suspend_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cyc == SSB_CYC_RD_CUR) |-> acc_addr == {burst_hi_r, cur_low} ##1 $stable(cur_low))
		else $error("suspend moved the address");

	burst_full_c: cover property (@(posedge clk_sys) disable iff (rst)
		(cyc == SSB_CYC_RD_EXT) ##1 (cyc == SSB_CYC_RD_NEXT)[*3]);

	processor_addr_strobe_n_write_c: cover property (@(posedge clk_sys) disable iff (rst)
		(processor_addr_strobe_n_go && sel) ##1 (cyc == SSB_CYC_WR_CUR));

	sleep_cycle_c: cover property (@(posedge clk_sys) disable iff (rst)
		asleep_r ##1 !asleep_r);

endmodule // ssb_sram_ctl

// ---- dv/ssb_bus_master.sv ----
module ssb_bus_master (
	// Clock
	input  wire logic                        clk_sys,
	// Bus toward the device
	output ssb_pkg::ssb_ctl_t                ctl,
	output logic [5:0]                       addr,
	output logic [ssb_pkg::SSB_DATA_W-1:0]   dq_in,
	output logic                             output_enable_n,
	output logic                             sleep_request
);
	timeunit 1ns;
	timeprecision 1ps;
	import ssb_pkg::*;

	initial begin
		ctl = ssb_ctl_t'{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf};
		addr = 6'h0;
		dq_in = '0;
		output_enable_n = 1'b1;
		sleep_request = 1'b0;
	end

	// One bus cycle, driven at the falling edge, held over the rising edge
	task automatic cyc(input logic sel, ps_n, cs_n, adv_n, gw_n, bwe_n, input logic [3:0] bl_n,
		input logic [5:0] a, input logic [SSB_DATA_W-1:0] d, input logic oe_n);
		@(negedge clk_sys);
		ctl <= ssb_ctl_t'{~sel, sel, ~sel, ps_n, cs_n, adv_n, gw_n, bwe_n, bl_n};
		addr <= a;
		dq_in <= d;
		output_enable_n <= oe_n;
		@(posedge clk_sys);
		#1;
	endtask

	// Deselects as it sets the request; two idle cycles follow the fall
	task automatic sleep_set(input logic v);
		@(negedge clk_sys);
		sleep_request <= v;
		ctl <= ssb_ctl_t'{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf};
		if (!v) begin
			repeat (2) cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, ~addr, ~dq_in, 1'b1);
		end
	endtask
endmodule // ssb_bus_master

// ---- dv/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ssb_pkg::*;

	logic              clk_sys;
	logic              rst;
	logic              order_sel;
	ssb_ctl_t          ctl;
	logic [5:0]        addr;
	logic [35:0]       dq_in;
	logic [35:0]       dq_out;
	logic              dq_oe;
	logic              output_enable_n;
	logic              sleep_request;
	logic [35:0]       mem [64];
	logic [5:0]        b;
	int                errors;
	int                samples_checked;
	int                seed;

	ssb_sram_ctl #(.ADDR_W(6)) dut (.clk_sys(clk_sys), .rst(rst), .ctl(ctl), .addr(addr),
		.burst_order_sel(order_sel), .sleep_request(sleep_request), .output_enable_n(output_enable_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	ssb_bus_master u_bm (.clk_sys(clk_sys), .ctl(ctl), .addr(addr), .dq_in(dq_in),
		.output_enable_n(output_enable_n), .sleep_request(sleep_request));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function automatic logic [35:0] rnd();
		return 36'({$random(seed), $random(seed)});
	endfunction

	function automatic logic [1:0] beat(input logic [1:0] s, input logic [1:0] i, input logic il);
		return il ? s ^ i : s + i;
	endfunction

	// Burst start write with output enable held high
	task automatic wr(input logic [5:0] a, input logic [35:0] d);
		u_bm.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf, a, d, 1'b1);
		mem[a] = d;
	endtask

	// Burst start read, processor strobe when ps is high
	task automatic rd(input logic ps, input logic [5:0] a, input logic oe_n);
		u_bm.cyc(1'b1, ~ps, ps, 1'b1, 1'b1, 1'b1, 4'hf, a, rnd(), oe_n);
		check("dq_out", dq_out, mem[a]);
		check("dq_oe", dq_oe, 36'(!oe_n));
	endtask

	// Continue or suspend with enables inactive; a is the expected beat address
	task automatic nx(input logic adv_n, gw_n, bwe_n, input logic [3:0] bl, input logic [5:0] a, input logic oe_n);
		logic [35:0] d;
		d = rnd();
		u_bm.cyc(1'b0, 1'b1, 1'b1, adv_n, gw_n, bwe_n, bl, ~a, d, oe_n);
		if (!gw_n || (!bwe_n && bl != 4'hf)) begin
			for (int l = 0; l < 4; l++) if (!gw_n || !bl[l]) mem[a][l*9 +: 9] = d[l*9 +: 9];
			check("dq_oe write", dq_oe, 36'h0);
		end else begin
			check("dq_out beat", dq_out, mem[a]);
			check("dq_oe beat", dq_oe, 36'(!oe_n));
		end
	endtask

	initial begin
		repeat (3000) @(posedge clk_sys);
		errors++;
		test_done();
	end

	initial begin
		seed = 49397;
		errors = 0;
		samples_checked = 0;
		order_sel = 1'b1;
		rst = 1'b1;
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		for (int a = 0; a < 64; a++) wr(6'(a), rnd());
		for (int o = 0; o < 2; o++) begin
			// Deselect closes the burst before the order select moves
			u_bm.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 6'h0, rnd(), 1'b0);
			check("dq_oe order desel", dq_oe, 36'h0);
			for (int s = 0; s < 4; s++) begin
				b = 6'($random(seed));
				b[1:0] = 2'(s);
				@(negedge clk_sys);
				order_sel <= o[0];
				rd(1'b0, b, 1'b0);
				for (int i = 1; i < 4; i++) nx(1'b0, 1'b1, 1'b1, 4'hf, {b[5:2], beat(b[1:0], 2'(i), o[0])}, 1'b0);
				nx(1'b1, 1'b1, 1'b1, 4'hf, {b[5:2], beat(b[1:0], 2'h3, o[0])}, 1'b1);
			end
		end
		b = 6'($random(seed));
		wr(b, rnd());
		for (int i = 1; i < 4; i++) nx(1'b0, 1'b1, 1'b0, 4'($random(seed)), {b[5:2], beat(b[1:0], 2'(i), 1'b1)}, 1'b0);
		nx(1'b1, 1'b0, 1'b1, 4'hf, {b[5:2], beat(b[1:0], 2'h3, 1'b1)}, 1'b0);
		rd(1'b1, b, 1'b0);
		for (int i = 1; i < 4; i++) nx(1'b0, 1'b1, 1'b1, 4'hf, {b[5:2], beat(b[1:0], 2'(i), 1'b1)}, 1'b0);
		b = 6'($random(seed));
		u_bm.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, b, rnd(), 1'b1);
		check("dq_out ps write", dq_out, mem[b]);
		check("dq_oe oe high", dq_oe, 36'h0);
		nx(1'b1, 1'b0, 1'b1, 4'hf, b, 1'b1);
		rd(1'b1, b, 1'b0);
		u_bm.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, b, rnd(), 1'b0);
		check("dq_oe desel", dq_oe, 36'h0);
		u_bm.sleep_set(1'b1);
		repeat (2) u_bm.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, b, rnd(), 1'b1);
		u_bm.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, b, rnd(), 1'b0);
		check("dq_oe asleep", dq_oe, 36'h0);
		u_bm.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf, b, ~mem[b], 1'b1);
		u_bm.sleep_set(1'b0);
		rd(1'b1, b, 1'b0);
		test_done();
	end
endmodule // testbench
